// file: irg_pkg.sv
package irg_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_MUX  = 8'h00;
  localparam logic [7:0] ADDR_PWR  = 8'h01;
  localparam logic [7:0] ADDR_TAT  = 8'h02;
  localparam logic [7:0] ADDR_UIS  = 8'h03;
  localparam logic [7:0] ADDR_ACT  = 8'h04;
  localparam logic [7:0] ADDR_CBL  = 8'h05;
  localparam logic [7:0] ADDR_CBH  = 8'h06;
  localparam logic [7:0] ADDR_SPF  = 8'h07;
  localparam logic [7:0] ADDR_SMS  = 8'h09;
  localparam logic [7:0] ADDR_SME  = 8'h0a;
  localparam logic [7:0] ADDR_CTL  = 8'h0b;
  localparam logic [7:0] ADDR_PMS  = 8'h0c;

  // Field positions
  localparam int MUX_TX_LO   = 6;
  localparam int MUX_CIR_LO  = 4;
  localparam int PWR_UART2   = 7;
  localparam int PWR_CIR     = 6;
  localparam int PWR_PLL     = 5;
  localparam int ACT_CIR     = 2;
  localparam int SMI_IR      = 1;
  localparam int CTL_HDX     = 0;
  localparam int CTL_SMI_PIN = 1;
  localparam int PMS_WAKE    = 0;
  localparam int SPF_LO      = 0;

  // Field codes
  localparam logic [1:0] MUX_FOLLOW = 2'h1;
  localparam logic [1:0] MUX_HIZ    = 2'h3;
  localparam logic [1:0] SPF_CLK32  = 2'h2;

  // Values after reset
  localparam logic [7:0] RST_REG = 8'h00;

  // Turnaround tick: 100 us at a 25 ns clock
  localparam int TICK_NS  = 100000;
  localparam int CLK_NS   = 25;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TICK_W   = 12;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // Direction of the IR controller
  typedef enum logic {DIR_RX, DIR_TX} irg_dir_e;

  // Signals from the IR controller
  typedef struct packed {
    logic tx_data;
    logic ir_mode_en;
    logic bit_done;
    logic rx_start;
    logic rx_busy;
    logic tx_pending;
    logic runtime_event;
  } irg_irc_s;

  // Consumer-IR power and clock controls
  typedef struct packed {
    logic       powered;
    logic       full_mode;
    logic       wake_only;
    logic       clk_pll;
    logic       pll_run;
    logic       wake_en;
    logic [1:0] out_mux;
  } irg_cir_s;

endpackage : irg_pkg

// file: irg_turnaround.sv
module irg_turnaround
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Control
  input  wire logic       restart,
  input  wire logic [7:0] steps,
  // Status
  output logic            expired
);

  logic [irg_pkg::TICK_W-1:0] pre_ff;
  logic [7:0]                 cnt_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pre_ff <= '0;
    else if (restart || pre_ff == irg_pkg::TICK_LAST)
      pre_ff <= '0;
    else
      pre_ff <= pre_ff + 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt_ff <= '0;
    else if (restart)
      cnt_ff <= steps;
    else if (cnt_ff != 8'h00 && pre_ff == irg_pkg::TICK_LAST)
      cnt_ff <= cnt_ff - 1'b1;
  end

  assign expired = (cnt_ff == 8'h00) && !restart;

  tick_step_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (!restart && cnt_ff != 8'h00 && pre_ff == irg_pkg::TICK_LAST)
      |=> cnt_ff == $past(cnt_ff) - 8'h01)
    else $error("turnaround count did not step on tick");

  tat_load_a: assert property (
    @(posedge clock) disable iff (!nrst)
    restart |=> (cnt_ff == $past(steps) && pre_ff == '0))
    else $error("turnaround count not loaded on restart");

endmodule : irg_turnaround

// file: irg_glue.sv
module irg_glue
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               bus_reset,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  // IR controller side
  input  wire irg_pkg::irg_irc_s  irc,
  output irg_pkg::irg_dir_e       dir_ff,
  // Serial IRQ side
  input  wire logic               ace_base_valid,
  input  wire logic               auxiliary_output_two,
  output logic      [3:0]         irq_channel,
  output logic                    sirq_req_ff,
  // Pins
  output logic                    ir_transmit_pin_o_ff,
  output logic                    ir_transmit_pin_oe_ff,
  input  wire logic               ir_receive_pin,
  output logic                    wake_event_output_n_ff,
  output logic                    smi_output_pin_n_ff,
  // Consumer-IR controls
  input  wire logic               main_power_on,
  input  wire logic               cir_cfgb_wr,
  input  wire logic [1:0]         cir_cfgb_mux,
  output irg_pkg::irg_cir_s       cir
);

  logic [7:0] mux_ff;
  logic [7:0] pwr_ff;
  logic [7:0] tat_ff;
  logic [7:0] uis_ff;
  logic [7:0] act_ff;
  logic [7:0] cbl_ff;
  logic [7:0] cbh_ff;
  logic [7:0] spf_ff;
  logic [7:0] sms_ff;
  logic [7:0] sme_ff;
  logic [7:0] ctl_ff;
  logic [7:0] pms_ff;
  logic       hold_ff;
  logic       rx_prev_ff;
  logic       rx_busy_ff;
  logic [7:0] nxt_rdata;
  logic       wr_hit_mux;
  logic       timer_restart;
  logic       timer_expired;
  logic       turn_ok;
  logic       wake_edge;
  logic       nxt_tx_o;
  logic       nxt_tx_oe;
  logic [1:0] tx_mux;
  logic       uart2_on;

  assign wr_hit_mux = reg_wr && reg_addr == irg_pkg::ADDR_MUX;
  assign tx_mux     = mux_ff[irg_pkg::MUX_TX_LO +: 2];
  assign uart2_on   = pwr_ff[irg_pkg::PWR_UART2];

  // Standby-held settings: main-power resets leave them alone
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mux_ff <= irg_pkg::RST_REG;
      act_ff <= irg_pkg::RST_REG;
      cbl_ff <= irg_pkg::RST_REG;
      cbh_ff <= irg_pkg::RST_REG;
      spf_ff <= irg_pkg::RST_REG;
      uis_ff <= irg_pkg::RST_REG;
      sme_ff <= irg_pkg::RST_REG;
    end
    else
    begin
      if (reg_wr)
      begin
        unique case (reg_addr)
          irg_pkg::ADDR_MUX: mux_ff <= reg_wdata;
          irg_pkg::ADDR_ACT: act_ff <= reg_wdata;
          irg_pkg::ADDR_CBL: cbl_ff <= reg_wdata;
          irg_pkg::ADDR_CBH: cbh_ff <= reg_wdata;
          irg_pkg::ADDR_SPF: spf_ff <= reg_wdata;
          irg_pkg::ADDR_UIS: uis_ff <= reg_wdata;
          irg_pkg::ADDR_SME: sme_ff <= reg_wdata;
          default: ;
        endcase
      end
      // second writer; only a bus write to the mux itself wins
      if (cir_cfgb_wr && !wr_hit_mux)
        mux_ff[irg_pkg::MUX_CIR_LO +: 2] <= cir_cfgb_mux;
    end
  end

  // Main-power registers, also cleared by bus reset
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pwr_ff <= irg_pkg::RST_REG;
      tat_ff <= irg_pkg::RST_REG;
      ctl_ff <= irg_pkg::RST_REG;
    end
    else if (bus_reset)
    begin
      pwr_ff <= irg_pkg::RST_REG;
      tat_ff <= irg_pkg::RST_REG;
      ctl_ff <= irg_pkg::RST_REG;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        irg_pkg::ADDR_PWR: pwr_ff <= reg_wdata;
        irg_pkg::ADDR_TAT: tat_ff <= reg_wdata;
        irg_pkg::ADDR_CTL: ctl_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Registered read data, zero when unmapped or idle
  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (reg_addr)
      irg_pkg::ADDR_MUX: nxt_rdata = mux_ff;
      irg_pkg::ADDR_PWR: nxt_rdata = pwr_ff;
      irg_pkg::ADDR_TAT: nxt_rdata = tat_ff;
      irg_pkg::ADDR_UIS: nxt_rdata = uis_ff;
      irg_pkg::ADDR_ACT: nxt_rdata = act_ff;
      irg_pkg::ADDR_CBL: nxt_rdata = cbl_ff;
      irg_pkg::ADDR_CBH: nxt_rdata = cbh_ff;
      irg_pkg::ADDR_SPF: nxt_rdata = spf_ff;
      irg_pkg::ADDR_SMS: nxt_rdata = sms_ff;
      irg_pkg::ADDR_SME: nxt_rdata = sme_ff;
      irg_pkg::ADDR_CTL: nxt_rdata = ctl_ff;
      irg_pkg::ADDR_PMS: nxt_rdata = pms_ff;
      default:           nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= nxt_rdata;
    else
      reg_rdata <= 8'h00;
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sms_ff <= irg_pkg::RST_REG;
    else
    begin
      if (reg_wr && reg_addr == irg_pkg::ADDR_SMS)
        sms_ff <= sms_ff & ~reg_wdata;
      if (irc.runtime_event)
        sms_ff[irg_pkg::SMI_IR] <= 1'b1;
    end
  end

  // SMI gated by enable and pin enable
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      smi_output_pin_n_ff <= 1'b1;
    else
      smi_output_pin_n_ff <= !(sms_ff[irg_pkg::SMI_IR]
                              && sme_ff[irg_pkg::SMI_IR]
                              && ctl_ff[irg_pkg::CTL_SMI_PIN]);
  end

  // serial IRQ request needs channel, base and aux two
  assign irq_channel = uis_ff[3:0];
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sirq_req_ff <= 1'b0;
    else
      sirq_req_ff <= sms_ff[irg_pkg::SMI_IR] && irq_channel != 4'h0
                     && ace_base_valid && auxiliary_output_two;
  end

  // single-sample falling edge, no filtering on purpose
  assign wake_edge = rx_prev_ff && !ir_receive_pin;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rx_prev_ff <= 1'b1;
    else
      rx_prev_ff <= ir_receive_pin;
  end

  // sticky wake flag, set wins over clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pms_ff <= irg_pkg::RST_REG;
    else
    begin
      if (reg_wr && reg_addr == irg_pkg::ADDR_PMS)
        pms_ff <= pms_ff & ~reg_wdata;
      if (wake_edge)
        pms_ff[irg_pkg::PMS_WAKE] <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      wake_event_output_n_ff <= 1'b1;
    else
      wake_event_output_n_ff <= !(pms_ff[irg_pkg::PMS_WAKE] || wake_edge);
  end

  // restart on each bit and at end of a reception
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rx_busy_ff <= 1'b0;
    else
      rx_busy_ff <= irc.rx_busy;
  end

  assign timer_restart = irc.bit_done || (rx_busy_ff && !irc.rx_busy);

  irg_turnaround u_turn
  (
    .clock   (clock),
    .nrst    (nrst),
    .restart (timer_restart),
    .steps   (tat_ff),
    .expired (timer_expired)
  );

  // with half duplex on, switch to transmit only when idle and timed out
  assign turn_ok = !ctl_ff[irg_pkg::CTL_HDX]
                   || (timer_expired && !irc.rx_busy && !irc.rx_start);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      dir_ff <= irg_pkg::DIR_RX;
    else
    begin
      unique case (dir_ff)
        irg_pkg::DIR_RX:
          if (irc.tx_pending && turn_ok)
            dir_ff <= irg_pkg::DIR_TX;
        irg_pkg::DIR_TX:
          if (!irc.tx_pending && irc.rx_start
              && (!ctl_ff[irg_pkg::CTL_HDX] || timer_expired))
            dir_ff <= irg_pkg::DIR_RX;
      endcase
    end
  end

  // hold low from any reset until the port is powered
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hold_ff <= 1'b1;
    else if (bus_reset)
      hold_ff <= 1'b1;
    else if (uart2_on)
      hold_ff <= 1'b0;
  end

  always_comb
  begin
    nxt_tx_o  = 1'b0;
    nxt_tx_oe = 1'b1;
    if (uart2_on && !hold_ff)
      nxt_tx_o = (tx_mux == irg_pkg::MUX_FOLLOW) && irc.ir_mode_en
                 && irc.tx_data;
    else if (!uart2_on && !hold_ff && tx_mux == irg_pkg::MUX_HIZ)
      nxt_tx_oe = 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ir_transmit_pin_o_ff  <= 1'b0;
      ir_transmit_pin_oe_ff <= 1'b1;
    end
    else if (bus_reset)
    begin
      ir_transmit_pin_o_ff  <= 1'b0;
      ir_transmit_pin_oe_ff <= 1'b1;
    end
    else
    begin
      ir_transmit_pin_o_ff  <= nxt_tx_o;
      ir_transmit_pin_oe_ff <= nxt_tx_oe;
    end
  end

  // powered only with base, activate and power bit
  // mode and clock follow main power
  // wake needs suspend clock pin and running PLL
  always_comb
  begin
    cir.powered   = (cbl_ff != 8'h00 || cbh_ff != 8'h00)
                    && act_ff[irg_pkg::ACT_CIR] && pwr_ff[irg_pkg::PWR_CIR];
    cir.full_mode = cir.powered && main_power_on;
    cir.wake_only = cir.powered && !main_power_on;
    cir.clk_pll   = !main_power_on;
    cir.pll_run   = !main_power_on && pwr_ff[irg_pkg::PWR_PLL];
    cir.wake_en   = cir.wake_only && cir.pll_run
                    && spf_ff[irg_pkg::SPF_LO +: 2] == irg_pkg::SPF_CLK32;
    // both writers land in the same field
    cir.out_mux   = mux_ff[irg_pkg::MUX_CIR_LO +: 2];
  end

  sequence rx_end_s;
    rx_busy_ff && !irc.rx_busy;
  endsequence

  sequence wait_turn_s;
    ctl_ff[irg_pkg::CTL_HDX] && (irc.rx_busy || !timer_expired);
  endsequence

  dir_hold_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (wait_turn_s and (dir_ff == irg_pkg::DIR_RX)) |=> dir_ff == irg_pkg::DIR_RX)
    else $error("direction changed before turnaround expired");

  rx_end_restart_a: assert property (
    @(posedge clock) disable iff (!nrst)
    rx_end_s |-> timer_restart)
    else $error("timer not restarted at end of reception");

  tx_wait_rx_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (ctl_ff[irg_pkg::CTL_HDX] && irc.rx_busy && dir_ff == irg_pkg::DIR_RX)
      |=> dir_ff == irg_pkg::DIR_RX)
    else $error("transmit started during reception");

  smi_status_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    irc.runtime_event |=> sms_ff[irg_pkg::SMI_IR])
    else $error("runtime event lost");

  smi_pin_gate_a: assert property (
    @(posedge clock) disable iff (!nrst)
    !smi_output_pin_n_ff |-> $past(sms_ff[irg_pkg::SMI_IR]
      && sme_ff[irg_pkg::SMI_IR] && ctl_ff[irg_pkg::CTL_SMI_PIN]))
    else $error("SMI asserted without its conditions");

  wake_edge_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ($fell(ir_receive_pin) ##1 1'b1) |-> !wake_event_output_n_ff[*2])
    else $error("receive falling edge gave no wake");

  tx_low_off_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (!uart2_on && !bus_reset) |=> !ir_transmit_pin_o_ff)
    else $error("transmit pin high while port powered down");

  tx_hiz_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (!uart2_on && !hold_ff && !bus_reset && tx_mux == irg_pkg::MUX_HIZ)
      |=> !ir_transmit_pin_oe_ff)
    else $error("transmit pin not released in mux 11");

  tx_follow_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (uart2_on && !hold_ff && !bus_reset && tx_mux == irg_pkg::MUX_FOLLOW
      && irc.ir_mode_en) |=> ir_transmit_pin_o_ff == $past(irc.tx_data))
    else $error("transmit pin not following IR output");

  bus_reset_low_a: assert property (
    @(posedge clock) disable iff (!nrst)
    bus_reset |=> (!ir_transmit_pin_o_ff && ir_transmit_pin_oe_ff)[*2])
    else $error("transmit pin not low after bus reset");

endmodule : irg_glue

// file: irg_ir_model.sv
module irg_ir_model
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Requests from the bench
  input  wire logic        rx_go,
  input  wire logic        tx_load,
  input  wire logic        tx_bit,
  input  wire logic        mode_en,
  input  wire logic        evt,
  // Controller and transceiver side
  output irg_pkg::irg_irc_s irc,
  output logic             ir_receive_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [10:0] RX_LEN = 11'h3e8;

  logic [10:0] cnt_ff;
  logic        start_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff   <= 11'h000;
      start_ff <= 1'b0;
    end
    else
    begin
      start_ff <= rx_go;
      if (rx_go)
        cnt_ff <= RX_LEN;
      else if (cnt_ff != 11'h000)
        cnt_ff <= cnt_ff - 11'h001;
    end
  end

  // One-cycle start pulse: wide enough for the single-sample wake edge detector
  assign ir_receive_pin = ~start_ff;
  assign irc = '{tx_data: tx_bit, ir_mode_en: mode_en,
                 bit_done: (cnt_ff == 11'h001), rx_start: start_ff,
                 rx_busy: (cnt_ff != 11'h000), tx_pending: tx_load,
                 runtime_event: evt};
endmodule : irg_ir_model

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0] mux;
    logic [7:0] pwr;
    logic       tx;
    logic       o;
    logic       oe;
  } irg_row_s;

  logic clock, nrst, bus_reset, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [3:0] irq_channel;
  logic ace_base_valid, auxiliary_output_two, sirq_req_ff;
  logic ir_transmit_pin_o_ff, ir_transmit_pin_oe_ff, ir_receive_pin;
  logic wake_event_output_n_ff, smi_output_pin_n_ff, main_power_on;
  logic cir_cfgb_wr, rx_go, tx_load, tx_bit, mode_en, evt;
  logic [1:0] cir_cfgb_mux;
  irg_pkg::irg_irc_s irc;
  irg_pkg::irg_dir_e dir_ff;
  irg_pkg::irg_cir_s cir;
  int errors, compares;
  irg_row_s rows [5];

  irg_glue uut (.clock(clock), .nrst(nrst), .bus_reset(bus_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irc(irc), .dir_ff(dir_ff),
    .ace_base_valid(ace_base_valid),
    .auxiliary_output_two(auxiliary_output_two),
    .irq_channel(irq_channel), .sirq_req_ff(sirq_req_ff),
    .ir_transmit_pin_o_ff(ir_transmit_pin_o_ff),
    .ir_transmit_pin_oe_ff(ir_transmit_pin_oe_ff),
    .ir_receive_pin(ir_receive_pin),
    .wake_event_output_n_ff(wake_event_output_n_ff),
    .smi_output_pin_n_ff(smi_output_pin_n_ff),
    .main_power_on(main_power_on), .cir_cfgb_wr(cir_cfgb_wr),
    .cir_cfgb_mux(cir_cfgb_mux), .cir(cir));

  irg_ir_model partner (.clock(clock), .nrst(nrst), .rx_go(rx_go),
    .tx_load(tx_load), .tx_bit(tx_bit), .mode_en(mode_en), .evt(evt),
    .irc(irc), .ir_receive_pin(ir_receive_pin));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  // Bounded wait: sel 0 for receive idle, sel 1 for transmit direction
  task automatic wait_on(input int sel, input int max);
    int i;
    for (i = 0; i < max; i++)
    begin
      if (sel == 0 && irc.rx_busy === 1'b0)
        return;
      if (sel == 1 && dir_ff === irg_pkg::DIR_TX)
        return;
      settle(1);
    end
    errors++;
    end_sim();
  endtask : wait_on

  task automatic pulse_rx;
    @(posedge clock);
    rx_go <= 1'b1;
    @(posedge clock);
    rx_go <= 1'b0;
  endtask : pulse_rx

  initial
  begin
    {nrst, bus_reset, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {ace_base_valid, auxiliary_output_two, cir_cfgb_wr} = '0;
    {rx_go, tx_load, tx_bit, evt, cir_cfgb_mux} = '0;
    {main_power_on, mode_en} = 2'h3;
    errors = 0;
    compares = 0;
    rows[0] = '{8'h40, 8'h00, 1'b1, 1'b0, 1'b1};
    rows[1] = '{8'h40, 8'h80, 1'b1, 1'b1, 1'b1};
    rows[2] = '{8'h40, 8'h80, 1'b0, 1'b0, 1'b1};
    rows[3] = '{8'h40, 8'h00, 1'b1, 1'b0, 1'b1};
    rows[4] = '{8'hc0, 8'h00, 1'b1, 1'b0, 1'b0};
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    settle(1);
    chk({ir_transmit_pin_o_ff, ir_transmit_pin_oe_ff}, 8'h01);
    chk(dir_ff, irg_pkg::DIR_RX);
    for (int a = 0; a < 13; a++)
    begin
      rd(8'(a));
      chk(rd_val, irg_pkg::RST_REG);
    end
    // Unmapped place ignores writes
    wr(8'h08, 8'hff);
    rd(8'h08);
    chk(rd_val, 8'h00);
    foreach (rows[i])
    begin
      wr(irg_pkg::ADDR_MUX, rows[i].mux);
      wr(irg_pkg::ADDR_PWR, rows[i].pwr);
      tx_bit <= rows[i].tx;
      settle(3);
      chk(ir_transmit_pin_oe_ff, rows[i].oe);
      if (rows[i].oe)
        chk(ir_transmit_pin_o_ff, rows[i].o);
    end
    // Bus reset overrides the high-z mux setting
    @(posedge clock);
    bus_reset <= 1'b1;
    @(posedge clock);
    bus_reset <= 1'b0;
    settle(1);
    chk({ir_transmit_pin_o_ff, ir_transmit_pin_oe_ff}, 8'h01);
    @(posedge clock);
    evt <= 1'b1;
    @(posedge clock);
    evt <= 1'b0;
    rd(irg_pkg::ADDR_SMS);
    chk(rd_val, 8'h02);
    wr(irg_pkg::ADDR_SME, 8'h02);
    settle(2);
    chk(smi_output_pin_n_ff, 1'b1);
    wr(irg_pkg::ADDR_CTL, 8'h02);
    settle(2);
    chk(smi_output_pin_n_ff, 1'b0);
    // software picks a channel, places the element, sets aux two
    wr(irg_pkg::ADDR_UIS, 8'h05);
    ace_base_valid <= 1'b1;
    auxiliary_output_two <= 1'b1;
    settle(2);
    chk(irq_channel, 8'h05);
    chk(sirq_req_ff, 1'b1);
    wr(irg_pkg::ADDR_SMS, 8'h02);
    settle(2);
    chk({smi_output_pin_n_ff, sirq_req_ff}, 8'h02);
    pulse_rx();
    settle(3);
    chk(wake_event_output_n_ff, 1'b0);
    rd(irg_pkg::ADDR_PMS);
    chk(rd_val, 8'h01);
    wr(irg_pkg::ADDR_PMS, 8'h01);
    settle(2);
    chk(wake_event_output_n_ff, 1'b1);
    wr(irg_pkg::ADDR_CBL, 8'h10);
    wr(irg_pkg::ADDR_ACT, 8'h04);
    settle(1);
    chk(cir.powered, 1'b0);
    wr(irg_pkg::ADDR_PWR, 8'h60);
    settle(1);
    chk({cir.powered, cir.full_mode, cir.clk_pll}, 8'h06);
    // Second writer lands beside a bus write to another register
    @(posedge clock);
    cir_cfgb_mux <= 2'h2;
    cir_cfgb_wr  <= 1'b1;
    reg_addr     <= irg_pkg::ADDR_ACT;
    reg_wdata    <= 8'h04;
    reg_wr       <= 1'b1;
    @(posedge clock);
    cir_cfgb_wr  <= 1'b0;
    reg_wr       <= 1'b0;
    settle(1);
    chk(cir.out_mux, 8'h02);
    rd(irg_pkg::ADDR_MUX);
    chk(rd_val, 8'he0);
    wr(irg_pkg::ADDR_SPF, 8'h02);
    main_power_on <= 1'b0;
    settle(2);
    chk({cir.pll_run, cir.clk_pll, cir.wake_only}, 8'h07);
    chk(cir.wake_en, 1'b1);
    @(posedge clock);
    main_power_on <= 1'b1;
    wait_on(0, 1200);
    wr(irg_pkg::ADDR_CTL, 8'h03);
    wr(irg_pkg::ADDR_TAT, 8'h01);
    pulse_rx();
    repeat (500) @(posedge clock);
    tx_load <= 1'b1;
    wait_on(0, 1200);
    chk(dir_ff, irg_pkg::DIR_RX);
    settle(2000);
    // Start bit inside the running timeout
    pulse_rx();
    settle(500);
    chk(dir_ff, irg_pkg::DIR_RX);
    wait_on(0, 1200);
    settle(3980);
    chk(dir_ff, irg_pkg::DIR_RX);
    wait_on(1, 40);
    chk(dir_ff, irg_pkg::DIR_TX);
    @(posedge clock);
    tx_load <= 1'b0;
    end_sim();
  end
endmodule : tb
